// *** logic/rss_fifo.v ***
// Purpose: Small FIFO with registered output stage.
// Assumes: Single clock, asynchronous active high reset.
// Notes: Holds DEPTH words in memory plus one in the output register.
`timescale 1ns/100ps

module rss_fifo #(
	parameter WIDTH = 17,
	parameter DEPTH = 16,
	parameter AW = 4
) (
	input wire clk,
	input wire reset,
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	output wire out_valid,
	input wire out_ready,
	output wire [WIDTH-1:0] out_data
);

	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wptr_r;
	reg [AW-1:0] rptr_r;
	reg [AW:0] cnt_r;
	reg out_valid_r;
	reg [WIDTH-1:0] out_data_r;
	wire push;
	wire pop;

	// ==========================================================
	// Flow control
	assign in_ready = (cnt_r != DEPTH[AW:0]);
	assign push = in_valid & in_ready;
	// Refill the output stage whenever it is empty or being taken
	assign pop = (cnt_r != {(AW+1){1'b0}}) & (~out_valid_r | out_ready);
	assign out_valid = out_valid_r;
	assign out_data = out_data_r;

	always @(posedge clk) begin
		if (push) begin
			mem[wptr_r] <= in_data;
		end
	end

	always @(posedge clk or posedge reset) begin
		if (reset) begin
			wptr_r <= {AW{1'b0}};
			rptr_r <= {AW{1'b0}};
			cnt_r <= {(AW+1){1'b0}};
			out_valid_r <= 1'b0;
			out_data_r <= {WIDTH{1'b0}};
		end else begin
			if (push) begin
				wptr_r <= wptr_r + {{(AW-1){1'b0}}, 1'b1};
			end
			if (pop) begin
				rptr_r <= rptr_r + {{(AW-1){1'b0}}, 1'b1};
				out_data_r <= mem[rptr_r];
				out_valid_r <= 1'b1;
			end else if (out_ready) begin
				out_valid_r <= 1'b0;
			end
			if (push & ~pop) begin
				cnt_r <= cnt_r + {{AW{1'b0}}, 1'b1};
			end else if (pop & ~push) begin
				cnt_r <= cnt_r - {{AW{1'b0}}, 1'b1};
			end
		end
	end

endmodule

// *** logic/rss_regs.vh ***
// Purpose: Shared constants of the serial slave front end.
// Assumes: Included by bare name from the design files.
// Notes: Definitions only.
`ifndef RSS_REGS_VH
`define RSS_REGS_VH

// ==========================================================
// Word pointer
`define RSS_PTR_RST 8'h00
`define RSS_PTR_ONE 8'h01
`define RSS_REG_TOP 8'h2F
`define RSS_SRAM_TOP 8'h7F

// ==========================================================
// Identification byte
`define RSS_RW_BIT 0
`define RSS_RW_READ 1'b1
`define RSS_SPACE_REG 1'b0
`define RSS_SPACE_SRAM 1'b1

// ==========================================================
// Bit counting
`define RSS_LAST_BIT 3'h7
`define RSS_BIT_ONE 3'h1

`endif

// *** logic/rss_slave.v ***
// Purpose: Two-wire serial slave front end of a real-time clock.
// Assumes: scl_in, sda_in, on_battery are asynchronous; clk >> bus clock.
// Notes: Written bytes leave through a FIFO; read bytes come from rd_data.
`timescale 1ns/100ps
`include "rss_regs.vh"

// Contract
// - Write: id, address, one data byte, then standby
// - Read: id-write, address, restart, id-read, all acked
// - Keep sending while master acks each byte
// - Pointer loaded from address, increments per byte
// - Pointer wraps 2Fh to 00h in registers, 7Fh to 00h in user memory, reads continue
// - Ignore bus while on backup battery
// - Recall calibration settings at power-up
// - Bytes shifted most significant bit first
// - Ack only identification matching either space
// - Pointer cleared to 00h at power-up
module rss_slave #(
	parameter [6:0] REG_ID = 7'h52,
	parameter [6:0] SRAM_ID = 7'h35,
	parameter FIFO_DEPTH = 16,
	parameter FIFO_AW = 4
) (
	input wire clk,
	input wire reset,
	input wire scl_in,
	input wire sda_in,
	output wire sda_out,
	output wire sda_oe_n,
	input wire on_battery,
	output wire recall_start,
	input wire recall_done,
	output wire recall_busy,
	output wire rd_space,
	output wire [7:0] rd_addr,
	input wire [7:0] rd_data,
	output wire wr_valid,
	input wire wr_ready,
	output wire wr_space,
	output wire [7:0] wr_addr,
	output wire [7:0] wr_data
);

	localparam [3:0] ST_IDLE = 4'h0;
	localparam [3:0] ST_DEV = 4'h1;
	localparam [3:0] ST_ACK_DEV = 4'h2;
	localparam [3:0] ST_WADDR = 4'h3;
	localparam [3:0] ST_ACK_ADDR = 4'h4;
	localparam [3:0] ST_WDATA = 4'h5;
	localparam [3:0] ST_ACK_DATA = 4'h6;
	localparam [3:0] ST_RDATA = 4'h7;
	localparam [3:0] ST_RACK = 4'h8;
	localparam [3:0] ST_IGNORE = 4'h9;

	// ==========================================================
	// Input synchronisers
	reg scl_s1_r;
	reg scl_s2_r;
	reg scl_s3_r;
	reg sda_s1_r;
	reg sda_s2_r;
	reg sda_s3_r;
	reg bat_s1_r;
	reg bat_s2_r;

	always @(posedge clk or posedge reset) begin
		if (reset) begin
			scl_s1_r <= 1'b1;
			scl_s2_r <= 1'b1;
			scl_s3_r <= 1'b1;
			sda_s1_r <= 1'b1;
			sda_s2_r <= 1'b1;
			sda_s3_r <= 1'b1;
			bat_s1_r <= 1'b0;
			bat_s2_r <= 1'b0;
		end else begin
			scl_s1_r <= scl_in;
			scl_s2_r <= scl_s1_r;
			scl_s3_r <= scl_s2_r;
			sda_s1_r <= sda_in;
			sda_s2_r <= sda_s1_r;
			sda_s3_r <= sda_s2_r;
			bat_s1_r <= on_battery;
			bat_s2_r <= bat_s1_r;
		end
	end

	wire scl_rise = scl_s2_r & ~scl_s3_r;
	wire scl_fall = ~scl_s2_r & scl_s3_r;
	wire bus_start = scl_s2_r & scl_s3_r & sda_s3_r & ~sda_s2_r;
	wire bus_stop = scl_s2_r & scl_s3_r & ~sda_s3_r & sda_s2_r;

	// ==========================================================
	// Power-up recall
	reg started_r;
	reg recall_start_r;
	reg recall_busy_r;

	always @(posedge clk or posedge reset) begin
		if (reset) begin
			started_r <= 1'b0;
			recall_start_r <= 1'b0;
			recall_busy_r <= 1'b1;
		end else begin
			started_r <= 1'b1;
			recall_start_r <= ~started_r;
			if (started_r & ~recall_start_r & recall_done) begin
				recall_busy_r <= 1'b0;
			end
		end
	end

	assign recall_start = recall_start_r;
	assign recall_busy = recall_busy_r;

	// Bus is deaf during battery operation and during the recall
	wire bus_off = bat_s2_r | recall_busy_r;

	// ==========================================================
	// Protocol engine
	reg [3:0] state_r;
	reg [2:0] cnt_r;
	reg byte_done_r;
	reg seen_rise_r;
	reg mack_r;
	reg [7:0] shreg_r;
	reg [7:0] tx_r;
	reg [7:0] ptr_r;
	reg space_r;
	reg rw_r;
	reg oe_n_r;
	reg sda_out_r;

	wire fifo_in_ready;
	wire [6:0] id_rx = shreg_r[7:1];
	wire id_reg = (id_rx == REG_ID);
	wire id_sram = (id_rx == SRAM_ID);
	wire [7:0] ptr_top = space_r ? `RSS_SRAM_TOP : `RSS_REG_TOP;
	// Wraps at the top of the selected space
	wire [7:0] ptr_inc = (ptr_r == ptr_top) ? `RSS_PTR_RST :
		ptr_r + `RSS_PTR_ONE;
	wire rx_state = (state_r == ST_DEV) | (state_r == ST_WADDR) |
		(state_r == ST_WDATA);
	wire ack_state = (state_r == ST_ACK_DEV) | (state_r == ST_ACK_ADDR) |
		(state_r == ST_ACK_DATA) | (state_r == ST_RACK);
	wire push = (state_r == ST_WDATA) & byte_done_r & scl_fall &
		fifo_in_ready & ~bus_off & ~bus_start & ~bus_stop;

	always @(posedge clk or posedge reset) begin
		if (reset) begin
			state_r <= ST_IDLE;
			cnt_r <= 3'h0;
			byte_done_r <= 1'b0;
			seen_rise_r <= 1'b0;
			mack_r <= 1'b0;
			shreg_r <= 8'h00;
			tx_r <= 8'h00;
			ptr_r <= `RSS_PTR_RST;
			space_r <= `RSS_SPACE_REG;
			rw_r <= 1'b0;
			oe_n_r <= 1'b1;
			sda_out_r <= 1'b0;
		end else if (bus_off) begin
			state_r <= ST_IDLE;
			oe_n_r <= 1'b1;
			byte_done_r <= 1'b0;
		end else if (bus_start) begin
			state_r <= ST_DEV;
			cnt_r <= 3'h0;
			byte_done_r <= 1'b0;
			oe_n_r <= 1'b1;
		end else if (bus_stop) begin
			state_r <= ST_IDLE;
			oe_n_r <= 1'b1;
			byte_done_r <= 1'b0;
		end else begin
			if (scl_rise & rx_state) begin
				shreg_r <= {shreg_r[6:0], sda_s2_r};
				cnt_r <= cnt_r + `RSS_BIT_ONE;
				byte_done_r <= (cnt_r == `RSS_LAST_BIT);
			end
			if (scl_rise & ack_state) begin
				seen_rise_r <= 1'b1;
				mack_r <= ~sda_s2_r;
			end
			if (scl_fall) begin
				case (state_r)
				ST_DEV: begin
					if (byte_done_r) begin
						byte_done_r <= 1'b0;
						seen_rise_r <= 1'b0;
						rw_r <= shreg_r[`RSS_RW_BIT];
						if (id_reg | id_sram) begin
							space_r <= id_sram;
							oe_n_r <= 1'b0;
							state_r <= ST_ACK_DEV;
						end else begin
							state_r <= ST_IGNORE;
						end
					end
				end
				ST_ACK_DEV: begin
					if (seen_rise_r) begin
						cnt_r <= 3'h0;
						if (rw_r == `RSS_RW_READ) begin
							tx_r <= {rd_data[6:0], 1'b0};
							oe_n_r <= rd_data[7];
							ptr_r <= ptr_inc;
							state_r <= ST_RDATA;
						end else begin
							oe_n_r <= 1'b1;
							state_r <= ST_WADDR;
						end
					end
				end
				ST_WADDR: begin
					if (byte_done_r) begin
						byte_done_r <= 1'b0;
						seen_rise_r <= 1'b0;
						ptr_r <= shreg_r;
						oe_n_r <= 1'b0;
						state_r <= ST_ACK_ADDR;
					end
				end
				ST_ACK_ADDR: begin
					if (seen_rise_r) begin
						oe_n_r <= 1'b1;
						cnt_r <= 3'h0;
						state_r <= ST_WDATA;
					end
				end
				ST_WDATA: begin
					if (byte_done_r) begin
						byte_done_r <= 1'b0;
						seen_rise_r <= 1'b0;
						// A full FIFO refuses the byte with no ack
						if (fifo_in_ready) begin
							ptr_r <= ptr_inc;
							oe_n_r <= 1'b0;
							state_r <= ST_ACK_DATA;
						end else begin
							state_r <= ST_IGNORE;
						end
					end
				end
				ST_ACK_DATA: begin
					if (seen_rise_r) begin
						oe_n_r <= 1'b1;
						state_r <= ST_IGNORE;
					end
				end
				ST_RDATA: begin
					if (cnt_r == `RSS_LAST_BIT) begin
						oe_n_r <= 1'b1;
						seen_rise_r <= 1'b0;
						state_r <= ST_RACK;
					end else begin
						cnt_r <= cnt_r + `RSS_BIT_ONE;
						oe_n_r <= tx_r[7];
						tx_r <= {tx_r[6:0], 1'b0};
					end
				end
				ST_RACK: begin
					if (seen_rise_r) begin
						cnt_r <= 3'h0;
						if (mack_r) begin
							tx_r <= {rd_data[6:0], 1'b0};
							oe_n_r <= rd_data[7];
							ptr_r <= ptr_inc;
							state_r <= ST_RDATA;
						end else begin
							oe_n_r <= 1'b1;
							state_r <= ST_IGNORE;
						end
					end
				end
				ST_IDLE: begin
					oe_n_r <= 1'b1;
				end
				ST_IGNORE: begin
					oe_n_r <= 1'b1;
				end
				default: begin
					oe_n_r <= 1'b1;
					state_r <= ST_IDLE;
				end
				endcase
			end
		end
	end

	assign sda_out = sda_out_r;
	assign sda_oe_n = oe_n_r;
	assign rd_space = space_r;
	assign rd_addr = ptr_r;

	// ==========================================================
	// Write path buffer
	wire [16:0] fifo_out;

	rss_fifo #(
		.WIDTH(17),
		.DEPTH(FIFO_DEPTH),
		.AW(FIFO_AW)
	) u_fifo (
		.clk(clk),
		.reset(reset),
		.in_valid(push),
		.in_ready(fifo_in_ready),
		.in_data({space_r, ptr_r, shreg_r}),
		.out_valid(wr_valid),
		.out_ready(wr_ready),
		.out_data(fifo_out)
	);

	assign wr_space = fifo_out[16];
	assign wr_addr = fifo_out[15:8];
	assign wr_data = fifo_out[7:0];

endmodule

// *** tb/rss_slave_assertions.sv ***
// Purpose: Port-level checks of the serial slave front end.
// Assumes: One clock domain, asynchronous active high reset.
// Notes: Bound to every rss_slave instance.
`timescale 1ns/100ps

module rss_chk (
	input wire clk,
	input wire reset,
	input wire scl_in,
	input wire sda_out,
	input wire sda_oe_n,
	input wire on_battery,
	input wire recall_start,
	input wire recall_done,
	input wire recall_busy,
	input wire [7:0] rd_addr,
	input wire wr_valid,
	input wire wr_ready,
	input wire wr_space,
	input wire [7:0] wr_addr,
	input wire [7:0] wr_data
);
	// ==========
	// Properties
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	property p_odr; sda_out == 1'b0; endproperty
	a_odr: assert property (p_odr) else $error("sda driven high");
	property p_bat; on_battery [*4] |-> sda_oe_n; endproperty
	a_bat: assert property (p_bat) else $error("bus on battery");
	property p_bsy; recall_busy |-> sda_oe_n; endproperty
	a_bsy: assert property (p_bsy) else $error("bus in recall");
	property p_rcl; recall_start |-> $past(reset, 2) ##1 !recall_start;
	endproperty
	a_rcl: assert property (p_rcl) else $error("recall pulse");
	property p_dne;
		$fell(recall_busy) |-> $past(recall_done) || $past(recall_done, 2);
	endproperty
	a_dne: assert property (p_dne) else $error("busy early");
	property p_ptr; $fell(reset) |-> rd_addr == 8'h00 && !wr_valid;
	endproperty
	a_ptr: assert property (p_ptr) else $error("pointer not 00");
	// Drive may only start while the bus clock is low
	property p_chg; $fell(sda_oe_n) |-> !scl_in; endproperty
	a_chg: assert property (p_chg) else $error("sda moved, scl high");
	property p_hld; $fell(sda_oe_n) |-> (!sda_oe_n) [*4]; endproperty
	a_hld: assert property (p_hld) else $error("drive too short");
	property p_wrs; wr_valid && !wr_ready |=>
		wr_valid && $stable({wr_space, wr_addr, wr_data}); endproperty
	a_wrs: assert property (p_wrs) else $error("record dropped");
	c_ack: cover property ($fell(sda_oe_n));
	c_wr: cover property (wr_valid && wr_ready);
	c_bat: cover property (on_battery && !recall_busy);
endmodule

bind rss_slave rss_chk chk_u (.clk(clk), .reset(reset), .scl_in(scl_in),
	.sda_out(sda_out), .sda_oe_n(sda_oe_n), .on_battery(on_battery),
	.recall_start(recall_start), .recall_done(recall_done),
	.recall_busy(recall_busy), .rd_addr(rd_addr), .wr_valid(wr_valid),
	.wr_ready(wr_ready), .wr_space(wr_space), .wr_addr(wr_addr),
	.wr_data(wr_data));

// *** tb/rss_tb_master.sv ***
// Purpose: Bus master model for the two-wire link.
// Assumes: 40 ns clock; one bit slot is 8 clocks, 320 ns.
// Notes: Open drain; a released line reads high through the pull-up.
`timescale 1ns/100ps

module rss_tb_master (
	input wire logic clk,
	input wire logic sda,
	output logic scl,
	output logic sda_m
);
	// ==========
	// Bus cycles
	initial begin
		scl = 1'b1;
		sda_m = 1'b1;
	end

	task automatic tk(input int n);
		repeat (n) @(posedge clk);
	endtask

	// Low 5 clocks so the slave's late data change lands first
	task automatic cyc(input logic b, output logic s);
		tk(1);
		sda_m <= b;
		tk(4);
		scl <= 1'b1;
		tk(2);
		s = sda;
		tk(1);
		scl <= 1'b0;
	endtask

	task automatic start();
		tk(1);
		sda_m <= 1'b1;
		tk(4);
		scl <= 1'b1;
		tk(4);
		sda_m <= 1'b0;
		tk(4);
		scl <= 1'b0;
	endtask

	task automatic stop();
		tk(1);
		sda_m <= 1'b0;
		tk(4);
		scl <= 1'b1;
		tk(4);
		sda_m <= 1'b1;
		tk(4);
	endtask

	task automatic xfer(input logic [7:0] d, input logic a,
		output logic [7:0] q, output logic k);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			cyc(d[i], s);
			q = {q[6:0], s};
		end
		cyc(a, k);
	endtask
endmodule

// *** tb/test_rtc_serial_slave_access.sv ***
// Purpose: Self-checking bench of the serial slave front end.
// Assumes: 25 MHz clock; the model paces link bits at 320 ns.
// Notes: Write FIFO filled to refusal, drained with random stalls.
`timescale 1ns/100ps

module test_rtc_serial_slave_access;
	// Arbitrary identification values
	localparam logic [6:0] RID = 7'h52;
	localparam logic [6:0] SID = 7'h35;
	logic clk, reset, on_battery, recall_done, wr_ready;
	logic [7:0] rd_data, a, b;
	logic [31:0] r;
	logic [3:0] ak;
	logic k, sp;
	logic [16:0] q[$];
	wire scl, sda_m, sda, sda_out, sda_oe_n, recall_start, recall_busy;
	wire rd_space, wr_valid, wr_space;
	wire [7:0] rd_addr, wr_addr, wr_data;
	int err_total = 0;
	int n_compared = 0;
	int seed = 58892;
	int i;

	assign sda = sda_m & (sda_oe_n | sda_out);
	rss_slave #(.REG_ID(RID), .SRAM_ID(SID)) dut_u (.clk(clk),
		.reset(reset), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
		.sda_oe_n(sda_oe_n), .on_battery(on_battery),
		.recall_start(recall_start), .recall_done(recall_done),
		.recall_busy(recall_busy), .rd_space(rd_space),
		.rd_addr(rd_addr), .rd_data(rd_data), .wr_valid(wr_valid),
		.wr_ready(wr_ready), .wr_space(wr_space), .wr_addr(wr_addr),
		.wr_data(wr_data));
	rss_tb_master m_u (.clk(clk), .sda(sda), .scl(scl), .sda_m(sda_m));

	// ==========
	// Helpers
	function automatic logic [7:0] mem(input logic s, input logic [7:0] p);
		return {p[6:0], s} ^ 8'hC3;
	endfunction

	always @(posedge clk)
		rd_data <= mem(rd_space, rd_addr);

	task automatic chk(input logic ok);
		n_compared++;
		if (ok !== 1'b1) begin
			err_total++;
			$display("unexpected at %0t ns: value mismatch", $time);
		end
	endtask

	task automatic final_report();
		$display("mismatches %0d compared %0d", err_total, n_compared);
		if (err_total == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic lim(input int n);
		if (n <= 0) begin
			err_total++;
			final_report();
		end
	endtask

	// START then n bytes; acks shift in so two calls can share one word
	task automatic sq(input logic [31:0] v, input int n,
		inout logic [3:0] ak);
		logic [7:0] x;
		logic y;
		m_u.start();
		for (int j = n - 1; j >= 0; j--) begin
			m_u.xfer(v[8*j +: 8], 1'b1, x, y);
			ak = {ak[2:0], ~y};
		end
	endtask

	// Pointer top differs per space: 2Fh registers, 7Fh user memory
	task automatic rd(input logic s, input logic [7:0] p);
		for (int j = 0; j < 4; j++) begin
			m_u.xfer(8'hFF, j == 3, b, k);
			chk(b === mem(s, p));
			if (p == (s ? 8'h7F : 8'h2F))
				p = 8'h00;
			else
				p = p + 8'h01;
		end
		m_u.stop();
	endtask

	// Release reset, probe the bus while the recall is still running
	task automatic boot();
		repeat (8) @(posedge clk);
		reset <= 1'b0;
		for (i = 20; i > 0 && recall_start !== 1'b1; i--)
			@(posedge clk);
		lim(i);
		chk(recall_busy === 1'b1);
		sq(32'({RID, 1'b0}), 1, ak);
		m_u.stop();
		chk(ak[0] === 1'b0);
		recall_done <= 1'b1;
		@(posedge clk);
		recall_done <= 1'b0;
		repeat (3) @(posedge clk);
		chk(recall_busy === 1'b0);
	endtask

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// ==========
	// Scenarios
	initial begin
		reset = 1'b1;
		on_battery = 1'b0;
		recall_done = 1'b0;
		wr_ready = 1'b0;
		boot();
		sq(32'({RID, 1'b1}), 1, ak);
		chk(ak[0] === 1'b1);
		rd(1'b0, 8'h00);
		on_battery <= 1'b1;
		repeat (4) @(posedge clk);
		sq(32'({RID, 1'b0}), 1, ak);
		m_u.stop();
		chk(ak[0] === 1'b0);
		on_battery <= 1'b0;
		repeat (4) @(posedge clk);
		sq(32'({7'h2A, 1'b0, 8'h11}), 2, ak);
		m_u.stop();
		chk(ak[1:0] === 2'b00);
		for (int n = 0; n < 18; n++) begin
			r = $random(seed);
			a = 8'(r[15:8] % 48);
			sq({r[16] ? SID : RID, 1'b0, a, r[7:0], r[7:0]}, 4, ak);
			m_u.stop();
			chk(ak === (n < 17 ? 4'hE : 4'hC));
			if (n < 17)
				q.push_back({r[16], a, r[7:0]});
		end
		for (i = 400; i > 0 && q.size() > 0; i--) begin
			@(posedge clk);
			if (wr_valid === 1'b1 && wr_ready === 1'b1)
				chk({wr_space, wr_addr, wr_data} === q.pop_front());
			wr_ready <= 1'($random(seed));
		end
		lim(i);
		wr_ready <= 1'b1;
		repeat (3) @(posedge clk);
		chk(wr_valid === 1'b0);
		// Second power-up while the pointer sits away from 00h
		reset <= 1'b1;
		boot();
		sq(32'({RID, 1'b1}), 1, ak);
		chk(ak[0] === 1'b1);
		rd(1'b0, 8'h00);
		for (int n = 0; n < 3; n++) begin
			r = $random(seed);
			sp = (n == 1);
			a = (n == 0) ? 8'h2E : (n == 1) ? 8'h7E :
				8'(r[15:0] % 48);
			sq(32'({sp ? SID : RID, 1'b0, a}), 2, ak);
			sq(32'({sp ? SID : RID, 1'b1}), 1, ak);
			chk(ak[2:0] === 3'b111);
			rd(sp, a);
		end
		final_report();
	end
endmodule
